// ==== aodi_consts.svh ====
// Purpose: timing counts and field layout for the sample output link
// Assumes: included by the package and both ends
// Notes:   codes of the strapped select pins are digitised upstream
`ifndef AODI_CONSTS_SVH
`define AODI_CONSTS_SVH
`define AODI_WORD_W          12
`define AODI_SIGN_BIT        11
`define AODI_FMT_W           2
`define AODI_FMT_GND         2'h0
`define AODI_FMT_THIRD       2'h1
`define AODI_FMT_TWOTHIRD    2'h2
`define AODI_FMT_SUPPLY      2'h3
`define AODI_PWR_W           2
`define AODI_PWR_GND         2'h0
`define AODI_PWR_HALF        2'h1
`define AODI_PWR_SUPPLY      2'h2
`define AODI_MIN_CODE        13'h1800
`define AODI_MAX_CODE        13'h07FF
`define AODI_RECOVER_NS      3000000
`define AODI_CLK_NS          50
`define AODI_RECOVER_CYC     ((`AODI_RECOVER_NS + `AODI_CLK_NS - 1) / `AODI_CLK_NS)
`define AODI_FIFO_DEPTH      16
`define AODI_ARM_CYC         3'h4
`endif

// ==== aodi_pkg.sv ====
// Purpose: shared types for the sample output link
// Assumes: aodi_consts.svh supplies the numbers
// Notes:   none
`include "aodi_consts.svh"
package aodi_pkg;
    typedef enum logic [1:0] {AODI_PWR_ON, AODI_PWR_SLEEP, AODI_PWR_DOWN} aodi_power_type;
    typedef struct packed {
        logic diff_clock;
        logic twos_comp;
    } aodi_mode_type;

    function automatic aodi_mode_type aodi_decode_mode(input logic [1:0] code);
        aodi_mode_type m;
        m.diff_clock = (code == `AODI_FMT_SUPPLY) || (code == `AODI_FMT_TWOTHIRD);
        m.twos_comp  = (code == `AODI_FMT_SUPPLY) || (code == `AODI_FMT_THIRD);
        return m;
    endfunction : aodi_decode_mode

    function automatic aodi_power_type aodi_decode_power(input logic [1:0] code);
        case (code)
            `AODI_PWR_SUPPLY: return AODI_PWR_DOWN;
            `AODI_PWR_HALF:   return AODI_PWR_SLEEP;
            default:          return AODI_PWR_ON;
        endcase
    endfunction : aodi_decode_power
endpackage : aodi_pkg

// ==== aodi_link_if.sv ====
// Purpose: pins between the converter output stage and the capture logic
// Assumes: sample_strobe is also the link clock on the capture side
// Notes:   spare pins carry no data
`timescale 1ns/100ps
`default_nettype none
interface aodi_link_if;
    logic        sample_strobe;
    logic [11:0] sample_word;
    logic        over_range_flag;
    logic [1:0]  spare_output_pins;
    logic        data_valid;
    modport device (output sample_strobe, output sample_word, output over_range_flag,
                    output spare_output_pins, output data_valid);
    modport host   (input sample_strobe, input sample_word, input over_range_flag,
                    input spare_output_pins, input data_valid);
endinterface : aodi_link_if
`default_nettype wire

// ==== aodi_fifo.sv ====
// Purpose: synchronous buffer between capture and the user side
// Assumes: single clock
// Notes:   full drops ready so the writer stalls
`timescale 1ns/100ps
`default_nettype none
module aodi_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    // clock and control
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_ce,
    input  wire logic             i_flush,
    // write side
    input  wire logic             i_wr_valid,
    input  wire logic [WIDTH-1:0] i_wr_data,
    output logic                  o_wr_ready,
    // read side
    output logic                  o_rd_valid,
    output logic      [WIDTH-1:0] o_rd_data,
    input  wire logic             i_rd_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic [AW:0]      cnt_reg;
    logic             do_wr;
    logic             do_rd;

    assign o_wr_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign o_rd_valid = (cnt_reg != '0);
    assign do_wr      = i_wr_valid && o_wr_ready;
    assign do_rd      = i_rd_ready && o_rd_valid;
    assign o_rd_data  = mem_reg[rp_reg];

    always_ff @(posedge i_clk)
    begin
        if (i_ce && do_wr)
        begin
            mem_reg[wp_reg] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n || (i_ce && i_flush))
        begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end
        else if (i_ce)
        begin
            if (do_wr)
            begin
                wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
            end
            if (do_rd)
            begin
                rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : aodi_fifo
`default_nettype wire

// ==== aodi_device.sv ====
// Purpose: converter output stage, clocked by the sampling clock
// Assumes: codes arrive as signed 13-bit value, straps pre-digitised
// Notes:   one sample per clock; data_valid low outside normal operation
`timescale 1ns/100ps
`default_nettype none
`include "aodi_consts.svh"
module aodi_device
    import aodi_pkg::*;
(
    // sampling clock and control
    input  wire logic        i_sample_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_ce,
    input  wire logic [1:0]  i_clock_format_select,
    input  wire logic [1:0]  i_power_state_select,
    // converted value
    input  wire logic [12:0] i_sample_code,
    // status
    output logic             o_diff_clock,
    // link
    aodi_link_if.device      link
);
    logic [1:0]  fmt_s1_reg, fmt_s2_reg, pwr_s1_reg, pwr_s2_reg;
    logic        rst_s1_reg, rst_s2_reg;
    logic [11:0] word_reg;
    logic        ovr_reg;
    logic        valid_reg;
    logic        rise_reg;
    logic        fall_reg;
    aodi_mode_type mode;
    logic        clip_hi, clip_lo;
    logic [11:0] clipped;

    // reset comes from another clock, so it is retimed like the straps
    always_ff @(posedge i_sample_clk)
    begin
        rst_s1_reg <= i_reset_n;
        rst_s2_reg <= rst_s1_reg;
    end

    always_ff @(posedge i_sample_clk)
    begin
        if (i_ce)
        begin
            fmt_s1_reg <= i_clock_format_select;
            fmt_s2_reg <= fmt_s1_reg;
            pwr_s1_reg <= i_power_state_select;
            pwr_s2_reg <= pwr_s1_reg;
        end
    end

    assign mode    = aodi_decode_mode(fmt_s2_reg);
    assign clip_hi = !i_sample_code[12] && (i_sample_code > `AODI_MAX_CODE);
    assign clip_lo = i_sample_code[12] && (i_sample_code < `AODI_MIN_CODE);
    assign clipped = clip_hi ? 12'h7FF : (clip_lo ? 12'h800 : i_sample_code[11:0]);
    assign o_diff_clock = mode.diff_clock;

    // a new word per sampling period, loaded with the clock so the strobe tracks it
    always_ff @(posedge i_sample_clk)
    begin
        if (!rst_s2_reg)
        begin
            word_reg  <= 12'h000;
            ovr_reg   <= 1'b0;
            valid_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            word_reg  <= mode.twos_comp ? clipped : {~clipped[11], clipped[10:0]};
            ovr_reg   <= clip_hi || clip_lo;
            valid_reg <= (aodi_decode_power(pwr_s2_reg) == AODI_PWR_ON);
        end
    end

    // strobe rises on the falling edge, mid-word, and falls with the next rising edge;
    // each flop moves on its own edge, so the exclusive-or cannot glitch
    always_ff @(negedge i_sample_clk)
    begin
        if (!rst_s2_reg)
        begin
            rise_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            rise_reg <= valid_reg ? ~fall_reg : fall_reg;
        end
    end

    always_ff @(posedge i_sample_clk)
    begin
        if (!rst_s2_reg)
        begin
            fall_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            fall_reg <= rise_reg;
        end
    end

    // high time is the low clock phase, so duty error only trades setup for hold
    assign link.sample_strobe     = rise_reg ^ fall_reg;
    assign link.sample_word       = word_reg;
    assign link.over_range_flag   = ovr_reg;
    assign link.spare_output_pins = 2'h0;
    assign link.data_valid        = valid_reg;
endmodule : aodi_device
`default_nettype wire

// ==== aodi_host.sv ====
// Purpose: capture logic: latches words on strobe rise, passes them to i_clk
// Function
// - four strap levels pick clock and coding
// - single-ended mode drives positive clock only
// - twelve-bit word per sample, chosen coding
// - over-range flag marks clipped samples
// - outputs valid only in normal operation
// - latch word and flag on strobe rise
// - keep sampling clock running continuously
// - stabilise clock duty cycle thirty to seventy; not done here, strobe high time is the raw low clock phase
// - ignore the spare output pins
// - three power levels: down, sleep, normal
// - discard data while down or sleeping
// Assumes: strobe period 15 ns in bench; i_clk 20 MHz is slower, so samples drop when full
// Notes:   word crossing uses a small gray-pointer async fifo of depth 4
`timescale 1ns/100ps
`default_nettype none
`include "aodi_consts.svh"
module aodi_host
    import aodi_pkg::*;
#(
    parameter int RECOVER_CYC = `AODI_RECOVER_CYC
) (
    // system clock
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_ce,
    // link
    aodi_link_if.host        link,
    // user side
    output logic             o_valid,
    output logic [11:0]      o_word,
    output logic             o_over_range,
    input  wire logic        i_ready,
    output logic             o_dropped
);
    localparam int XW = 13;
    // link domain, clocked by the strobe
    logic [XW-1:0] xmem_reg [4];
    logic [2:0]    wbin_reg, wgray_reg;
    logic [2:0]    rg_s1_reg, rg_s2_reg;
    logic          lrst_s1_reg, lrst_s2_reg;
    logic          xfull;
    // system domain, except drop_t_reg, which the strobe clocks
    logic [2:0]    rbin_reg, rgray_reg;
    logic [2:0]    wg_s1_reg, wg_s2_reg;
    logic          v_s1_reg, v_s2_reg;
    logic          drop_t_s1_reg, drop_t_s2_reg, drop_t_s3_reg;
    logic          drop_t_reg;
    logic [2:0]    arm_cnt_reg;
    logic          link_run_reg;
    logic [31:0]   recov_reg;
    logic          settled;
    logic          xempty;
    logic          f_wr_ready;
    logic          f_valid;
    logic [XW-1:0] f_data;
    logic          take;

    function automatic logic [2:0] bin2gray(input logic [2:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    // strobes stop while the device is idle or in reset, so a copy of the system
    // reset could never land here; the release comes from the system side instead
    always_ff @(posedge link.sample_strobe)
    begin
        lrst_s1_reg <= link_run_reg;
        lrst_s2_reg <= lrst_s1_reg;
        rg_s1_reg   <= rgray_reg;
        rg_s2_reg   <= rg_s1_reg;
    end

    assign xfull = (wgray_reg == {~rg_s2_reg[2:1], rg_s2_reg[0]});

    // spare pins deliberately not stored
    always_ff @(posedge link.sample_strobe)
    begin
        if (!xfull)
        begin
            xmem_reg[wbin_reg[1:0]] <= {link.over_range_flag, link.sample_word};
        end
    end

    always_ff @(posedge link.sample_strobe)
    begin
        if (!lrst_s2_reg)
        begin
            wbin_reg   <= 3'h0;
            wgray_reg  <= 3'h0;
            drop_t_reg <= 1'b0;
        end
        else if (xfull)
        begin
            drop_t_reg <= ~drop_t_reg;
        end
        else
        begin
            wbin_reg  <= wbin_reg + 3'h1;
            wgray_reg <= bin2gray(wbin_reg + 3'h1);
        end
    end

    // system side
    always_ff @(posedge i_clk)
    begin
        if (i_ce)
        begin
            wg_s1_reg     <= wgray_reg;
            wg_s2_reg     <= wg_s1_reg;
            v_s1_reg      <= link.data_valid;
            v_s2_reg      <= v_s1_reg;
            drop_t_s1_reg <= drop_t_reg;
            drop_t_s2_reg <= drop_t_s1_reg;
            drop_t_s3_reg <= drop_t_s2_reg;
        end
    end

    // writes start only once valid has stood for a few cycles, long enough for
    // the cleared write pointer to be seen here before reads resume
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n || (i_ce && !v_s2_reg))
        begin
            arm_cnt_reg  <= 3'h0;
            link_run_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            if (arm_cnt_reg != `AODI_ARM_CYC)
            begin
                arm_cnt_reg <= arm_cnt_reg + 3'h1;
            end
            link_run_reg <= (arm_cnt_reg == `AODI_ARM_CYC);
        end
    end

    assign xempty  = (rgray_reg == wg_s2_reg);
    assign settled = (recov_reg == 32'h0);
    assign take    = !xempty && i_ce && link_run_reg;

    // recovery wait restarts whenever the device leaves normal operation
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            recov_reg <= 32'(RECOVER_CYC);
        end
        else if (i_ce)
        begin
            if (!v_s2_reg)
            begin
                recov_reg <= 32'(RECOVER_CYC);
            end
            else if (!settled)
            begin
                recov_reg <= recov_reg - 32'h1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n || (i_ce && !link_run_reg))
        begin
            rbin_reg  <= 3'h0;
            rgray_reg <= 3'h0;
        end
        else if (take)
        begin
            rbin_reg  <= rbin_reg + 3'h1;
            rgray_reg <= bin2gray(rbin_reg + 3'h1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            o_dropped <= 1'b0;
        end
        else if (i_ce)
        begin
            o_dropped <= link_run_reg &&
                         ((drop_t_s3_reg != drop_t_s2_reg) || (take && !f_wr_ready));
        end
    end

    // words are popped always; only settled ones with room enter the buffer
    aodi_fifo #(
        .WIDTH (XW),
        .DEPTH (`AODI_FIFO_DEPTH)
    ) u_fifo (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_ce       (i_ce),
        .i_flush    (!v_s2_reg),
        .i_wr_valid (take && settled && v_s2_reg),
        .i_wr_data  (xmem_reg[rbin_reg[1:0]]),
        .o_wr_ready (f_wr_ready),
        .o_rd_valid (f_valid),
        .o_rd_data  (f_data),
        .i_rd_ready (i_ready)
    );

    assign o_valid      = f_valid;
    assign o_word       = f_data[11:0];
    assign o_over_range = f_data[12];
endmodule : aodi_host
`default_nettype wire

// ==== aodi_link_properties.sv ====
// Purpose: timing checks on the sample link
// Assumes: strobe rises mid-cycle of the sampling clock
// Notes:   counters tie strobe rises to sampling clocks
`timescale 1ns/100ps
`default_nettype none
module aodi_link_properties (
    // clock and reset
    input  wire logic        i_sample_clk,
    input  wire logic        i_reset_n,
    // link
    input  wire logic        sample_strobe,
    input  wire logic [11:0] sample_word,
    input  wire logic        over_range_flag,
    input  wire logic [1:0]  spare_output_pins,
    input  wire logic        data_valid
);
    logic [15:0] clk_cnt_reg;
    logic [15:0] rise_cnt_reg;
    logic [2:0]  run_reg;
    logic [11:0] cap_word_reg;
    logic        cap_ovr_reg;

    always_ff @(posedge i_sample_clk)
    begin
        clk_cnt_reg <= i_reset_n ? clk_cnt_reg + 16'h0001 : 16'h0000;
    end

    // only long valid runs are judged, so start-up latency never fires a check
    always_ff @(posedge i_sample_clk)
    begin
        if (!i_reset_n || !data_valid)
            run_reg <= 3'h0;
        else if (run_reg != 3'h7)
            run_reg <= run_reg + 3'h1;
    end

    always_ff @(posedge sample_strobe)
    begin
        rise_cnt_reg <= clk_cnt_reg;
        cap_word_reg <= sample_word;
        cap_ovr_reg  <= over_range_flag;
    end

    sequence s_idle;
        !data_valid [*3];
    endsequence

    sequence s_long_run;
        run_reg == 3'h7;
    endsequence

    a_strobe_needs_valid: assert property (@(posedge sample_strobe) disable iff (!i_reset_n)
        data_valid) else $error("strobe without valid data");
    a_one_strobe_clock: assert property (@(posedge sample_strobe) disable iff (!i_reset_n)
        s_long_run |-> clk_cnt_reg - rise_cnt_reg == 16'h0001) else $error("strobe rate wrong");
    a_strobe_keeps_pace: assert property (@(posedge i_sample_clk) disable iff (!i_reset_n)
        s_long_run |-> clk_cnt_reg - rise_cnt_reg <= 16'h0001) else $error("strobes missing");
    a_word_held_high: assert property (@(negedge sample_strobe) disable iff (!i_reset_n)
        sample_word == cap_word_reg && over_range_flag == cap_ovr_reg)
        else $error("word moved while strobe high");
    a_ovr_full_scale: assert property (@(posedge sample_strobe) disable iff (!i_reset_n)
        over_range_flag |-> sample_word inside {12'h000, 12'h7FF, 12'h800, 12'hFFF})
        else $error("over range word not clipped");
    a_spare_pins_zero: assert property (@(posedge i_sample_clk) disable iff (!i_reset_n)
        spare_output_pins == 2'h0) else $error("spare pins driven");
    a_idle_no_strobe: assert property (@(posedge i_sample_clk) disable iff (!i_reset_n)
        s_idle |-> !sample_strobe) else $error("strobe while invalid");
    a_reset_exit_quiet: assert property (@(posedge i_sample_clk) disable iff (!i_reset_n)
        $rose(i_reset_n) |-> !data_valid && sample_word == 12'h000 && !over_range_flag)
        else $error("outputs not cleared by reset");
endmodule : aodi_link_properties
`default_nettype wire

// ==== tb_adc_output_data_interface.sv ====
// Purpose: end-to-end bench of converter link and capture
// Assumes: host recovery cut to 8 cycles
// Notes:   host clock is slower than samples, so drops are normal
`timescale 1ns/100ps
`default_nettype none
`include "aodi_consts.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((ex) !== (got)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_adc_output_data_interface;
    import aodi_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_sample_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [1:0]  fmt = 2'h0;
    logic [1:0]  pwr = 2'h0;
    logic [12:0] code = 13'h0000;
    logic        i_ready = 1'b0;
    logic        diff;
    logic        o_valid;
    logic        o_over_range;
    logic        o_dropped;
    logic [11:0] o_word;
    logic [11:0] w;
    logic        ov;
    logic        drop_seen = 1'b0;
    int          fails = 0;
    int          n_compared = 0;
    int          cycles = 0;
    logic [12:0] codes [6] = '{13'h0000, 13'h07FF, 13'h1800, 13'h0800, 13'h17FF, 13'h0123};

    aodi_link_if link ();
    always #25 i_clk = ~i_clk;
    // odd start offset keeps the two clocks out of step
    initial #3.3 forever #7.5 i_sample_clk = ~i_sample_clk;

    aodi_device aodi_device_inst (.i_sample_clk(i_sample_clk), .i_reset_n(i_reset_n),
        .i_ce(1'b1), .i_clock_format_select(fmt), .i_power_state_select(pwr),
        .i_sample_code(code), .o_diff_clock(diff), .link(link));
    aodi_host #(.RECOVER_CYC(8)) aodi_host_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_ce(1'b1), .link(link), .o_valid(o_valid), .o_word(o_word),
        .o_over_range(o_over_range), .i_ready(i_ready), .o_dropped(o_dropped));
    aodi_link_properties aodi_link_properties_inst (.i_sample_clk(i_sample_clk),
        .i_reset_n(i_reset_n), .sample_strobe(link.sample_strobe),
        .sample_word(link.sample_word), .over_range_flag(link.over_range_flag),
        .spare_output_pins(link.spare_output_pins), .data_valid(link.data_valid));

    function automatic logic [12:0] expect_out(input logic [12:0] c, input logic [1:0] f);
        logic [12:0] v;
        logic        o;
        v = c;
        o = 1'b0;
        if ($signed(c) > $signed(`AODI_MAX_CODE))
        begin
            v = `AODI_MAX_CODE;
            o = 1'b1;
        end
        if ($signed(c) < $signed(`AODI_MIN_CODE))
        begin
            v = `AODI_MIN_CODE;
            o = 1'b1;
        end
        return {o, v[11:0] ^ ((f == `AODI_FMT_SUPPLY || f == `AODI_FMT_THIRD) ? 12'h000 : 12'h800)};
    endfunction : expect_out

    task automatic final_report();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic pop_word(output logic [11:0] wd, output logic of);
        int k;
        k = 0;
        @(negedge i_clk);
        while (o_valid !== 1'b1 && k < 200)
        begin
            @(negedge i_clk);
            k++;
        end
        wd = o_word;
        of = o_over_range;
        i_ready = 1'b1;
        @(negedge i_clk);
        i_ready = 1'b0;
    endtask : pop_word

    always @(posedge i_clk)
    begin
        cycles++;
        if (o_dropped === 1'b1)
            drop_seen = 1'b1;
        if (cycles == 20000)
        begin
            fails++;
            final_report();
        end
    end

    initial
    begin
        repeat (10) @(negedge i_clk);
        i_reset_n = 1'b1;
        for (int f = 0; f < 4; f++)
            for (int k = 0; k < 6; k++)
            begin
                fmt = 2'(f);
                code = codes[k];
                repeat (30) pop_word(w, ov);
                `CHK("diff_clock", 1'(f >= 2), diff)
                repeat (3)
                begin
                    pop_word(w, ov);
                    `CHK("word", expect_out(code, fmt), {ov, w})
                end
            end
        // stall the reader so the buffer fills and refuses
        drop_seen = 1'b0;
        repeat (40) @(negedge i_clk);
        `CHK("dropped_when_full", 1'b1, drop_seen)
        `CHK("head_when_full", 1'b1, o_valid)
        for (int p = 1; p < 3; p++)
        begin
            pwr = 2'(p);
            repeat (10) @(negedge i_clk);
            `CHK("valid_while_off", 1'b0, o_valid)
            pwr = `AODI_PWR_GND;
            repeat (10) @(negedge i_clk);
            `CHK("valid_recovering", 1'b0, o_valid)
            pop_word(w, ov);
            `CHK("word_after_wake", expect_out(code, fmt), {ov, w})
        end
        final_report();
    end
endmodule : tb_adc_output_data_interface
`default_nettype wire
